// >>> rtl/osa_adder.sv
`timescale 1ns/10ps
module osa_adder
  import osa_pkg::*;
#(
  parameter int N = MAX_CONTRIB
)
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Held values
  input  wire logic [N*OBS_W-1:0]   values,
  input  wire logic [N-1:0]         used,
  // Registered total
  output logic      [SUM_W-1:0]     total
);

  initial
  begin
    if (N < 1 || N > MAX_CONTRIB)
      $error("osa_adder: N out of range");
  end

  // ---------------------------------------------------------------
  // Total of configured slots
  // ---------------------------------------------------------------
  logic [SUM_W-1:0] acc_nxt;

  always_comb
  begin
    acc_nxt = '0;
    for (int i = 0; i < N; i++)
      if (used[i])
        acc_nxt = acc_nxt + SUM_W'(values[i*OBS_W +: OBS_W]);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      total <= '0;
    else
      total <= acc_nxt;
  end

endmodule : osa_adder

// >>> rtl/osa_pkg.sv
package osa_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int          MAX_CONTRIB   = 8;
  localparam int          OBS_W         = 8;
  localparam int          SUM_W         = 11;
  localparam int          ADDR_W        = 8;

  // ---------------------------------------------------------------
  // Fixed-point limits, units of 0.1 %/ft
  // ---------------------------------------------------------------
  localparam logic [7:0]  THR_MIN       = 8'h0a;
  localparam logic [7:0]  THR_MAX       = 8'h64;
  localparam logic [7:0]  THR_STEP      = 8'h05;
  localparam logic [7:0]  THR_RST       = 8'h28;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_THRESH    = 8'h04;
  localparam logic [7:0]  REG_SUM       = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0c;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  REG_CONTRIB0  = 8'h20;
  localparam logic [7:0]  REG_VALUE0    = 8'h40;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_TYPE_LSB = 4;
  localparam int          CTRL_RPT_LSB  = 8;
  localparam int          CTRL_LOOP_LSB = 12;

  // ---------------------------------------------------------------
  // Status / interrupt bits
  // ---------------------------------------------------------------
  localparam int          ST_REACHED    = 0;
  localparam int          ST_CLEARED    = 1;
  localparam int          ST_REPORT     = 2;
  localparam int          ST_REJECT     = 3;
  localparam int          ST_W          = 4;

  // ---------------------------------------------------------------
  // Detector types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DET_PHOTO      = 3'h0,
    DET_PHOTO_HEAT = 3'h1,
    DET_PHOTO_DUCT = 3'h2,
    DET_ION        = 3'h3,
    DET_OTHER      = 3'h4
  } osa_det_t;

  // ---------------------------------------------------------------
  // Reported states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RPT_ALARM       = 3'h0,
    RPT_SUM_ALARM   = 3'h1,
    RPT_SUPV_LATCH  = 3'h2,
    RPT_SUPV_NOLAT  = 3'h3,
    RPT_PRE_ALARM1  = 3'h4,
    RPT_PRE_ALARM2  = 3'h5
  } osa_rpt_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        loop_id;
    logic [ADDR_W-1:0] addr;
    osa_det_t          det;
    logic [OBS_W-1:0]  obs;
  } osa_report_t;

  typedef struct packed {
    logic              active;
    osa_rpt_t          state;
  } osa_panel_t;

endpackage : osa_pkg

// >>> rtl/osa_summer.sv
`timescale 1ns/10ps
module osa_summer
  import osa_pkg::*;
#(
  parameter int N = MAX_CONTRIB
)
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Loop report input
  input  wire logic          rpt_valid,
  input  wire osa_report_t   rpt,
  // Panel report
  output osa_panel_t         panel,
  output logic               irq
);

  initial
  begin
    if (N < 1 || N > MAX_CONTRIB)
      $error("osa_summer: N out of range");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic type_ok(input osa_det_t d);
    type_ok = (d == DET_PHOTO) || (d == DET_PHOTO_HEAT) || (d == DET_PHOTO_DUCT) || (d == DET_ION);
  endfunction : type_ok

  function automatic logic thr_ok(input logic [7:0] t);
    thr_ok = (t >= THR_MIN) && (t <= THR_MAX) && ((t % THR_STEP) == 8'h00);
  endfunction : thr_ok

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic                  en_r;
  osa_det_t              own_type_r;
  osa_rpt_t              rpt_state_r;
  logic [3:0]            own_loop_r;
  logic [7:0]            thresh_r;
  logic [ST_W-1:0]       status_r;
  logic [ST_W-1:0]       mask_r;
  logic [ADDR_W-1:0]     c_addr_r  [N];
  logic [N-1:0]          c_used_r;
  logic [OBS_W-1:0]      c_val_r   [N];
  logic [N*OBS_W-1:0]    val_flat;
  logic [SUM_W-1:0]      sum;
  logic                  reached_r;

  wire  logic            acc_phase = psel && penable && pready;
  wire  logic            wr_acc    = acc_phase && pwrite;
  wire  logic            rd_acc    = acc_phase && !pwrite;
  wire  logic [5:0]      widx      = paddr[7:2];
  wire  logic            ctrl_ok   = type_ok(osa_det_t'(pwdata[CTRL_TYPE_LSB +: 3]))
                                     && (pwdata[CTRL_RPT_LSB +: 3] <= 3'h5);

  // ---------------------------------------------------------------
  // APB handshake: one wait state, answer in the access phase
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  // Configuration, rejected writes leave it unchanged
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      en_r        <= 1'b0;
      own_type_r  <= DET_PHOTO;
      rpt_state_r <= RPT_SUM_ALARM;
      own_loop_r  <= 4'h0;
    end
    else if (wr_acc && paddr == REG_CTRL && ctrl_ok)
    begin
      en_r        <= pwdata[CTRL_EN_BIT];
      own_type_r  <= osa_det_t'(pwdata[CTRL_TYPE_LSB +: 3]);
      rpt_state_r <= osa_rpt_t'(pwdata[CTRL_RPT_LSB +: 3]);
      own_loop_r  <= pwdata[CTRL_LOOP_LSB +: 4];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      thresh_r <= THR_RST;
    else if (wr_acc && paddr == REG_THRESH && thr_ok(pwdata[7:0]))
      thresh_r <= pwdata[7:0];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mask_r <= '0;
    else if (wr_acc && paddr == REG_IRQ_MASK)
      mask_r <= pwdata[ST_W-1:0];
  end

  // ---------------------------------------------------------------
  // Contributor table; own address may appear as any slot
  // ---------------------------------------------------------------
  logic [N-1:0] hit;

  always_comb
  begin
    for (int i = 0; i < N; i++)
      hit[i] = c_used_r[i] && (c_addr_r[i] == rpt.addr);
  end

  wire logic rpt_ok = rpt_valid && en_r && rpt.det == own_type_r
                      && rpt.loop_id == own_loop_r && type_ok(rpt.det);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      c_used_r <= '0;
      for (int i = 0; i < N; i++)
      begin
        c_addr_r[i] <= '0;
        c_val_r[i]  <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (wr_acc && widx == 6'(REG_CONTRIB0 >> 2) + 6'(i))
        begin
          c_addr_r[i] <= pwdata[ADDR_W-1:0];
          c_used_r[i] <= pwdata[16];
          c_val_r[i]  <= '0;
        end
        else if (rpt_ok && hit[i])
          c_val_r[i] <= rpt.obs;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < N; i++)
      val_flat[i*OBS_W +: OBS_W] = c_val_r[i];
  end

  // Accumulator of 11 bits holds eight 8-bit values
  osa_adder #(.N(N)) u_adder
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .values  (val_flat),
    .used    (c_used_r),
    .total   (sum)
  );

  // ---------------------------------------------------------------
  // Threshold compare and panel report
  // ---------------------------------------------------------------
  wire logic reach_now = en_r && (sum >= SUM_W'(thresh_r));
  wire logic latching  = (rpt_state_r == RPT_SUPV_LATCH);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reached_r <= 1'b0;
    else
      reached_r <= reach_now;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      panel <= '{active: 1'b0, state: RPT_SUM_ALARM};
    else if (!en_r)
      panel <= '{active: 1'b0, state: rpt_state_r};
    else if (reach_now)
      panel <= '{active: 1'b1, state: rpt_state_r};
    else if (!(latching && panel.active))
      panel <= '{active: 1'b0, state: rpt_state_r};
  end

  // ---------------------------------------------------------------
  // Sticky status, cleared by read; new events win
  // ---------------------------------------------------------------
  logic [ST_W-1:0] ev;

  always_comb
  begin
    ev              = '0;
    ev[ST_REACHED]  = reach_now && !reached_r;
    ev[ST_CLEARED]  = !reach_now && reached_r;
    ev[ST_REPORT]   = rpt_ok && (|hit);
    ev[ST_REJECT]   = rpt_valid && !(rpt_ok && (|hit));
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      status_r <= '0;
    else if (rd_acc && paddr == REG_STATUS)
      // Clear only the bits returned, so an event after the capture is kept
      status_r <= (status_r & ~prdata[ST_W-1:0]) | ev;
    else
      status_r <= status_r | ev;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic        err_nxt;

  always_comb
  begin
    rd_nxt  = '0;
    err_nxt = 1'b0;
    case (paddr)
      REG_CTRL:     rd_nxt = {16'h0000, own_loop_r, 1'b0, rpt_state_r, 1'b0, own_type_r, 3'h0, en_r};
      REG_THRESH:   rd_nxt = {24'h000000, thresh_r};
      REG_SUM:      rd_nxt = {21'h000000, sum};
      REG_STATUS:   rd_nxt = {28'h0000000, status_r};
      REG_IRQ_MASK: rd_nxt = {28'h0000000, mask_r};
      default:
      begin
        if (paddr[1:0] == 2'h0 && widx >= 6'(REG_CONTRIB0 >> 2) && widx < 6'(REG_CONTRIB0 >> 2) + 6'(N))
          rd_nxt = {15'h0000, c_used_r[3'(widx - 6'(REG_CONTRIB0 >> 2))], 8'h00,
                    c_addr_r[3'(widx - 6'(REG_CONTRIB0 >> 2))]};
        else if (paddr[1:0] == 2'h0 && widx >= 6'(REG_VALUE0 >> 2) && widx < 6'(REG_VALUE0 >> 2) + 6'(N))
          rd_nxt = {24'h000000, c_val_r[3'(widx - 6'(REG_VALUE0 >> 2))]};
        else
          err_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_nxt;
      pslverr <= err_nxt;
    end
    else
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  thr_range_a: assert property (@(posedge sys_clk) disable iff (rst) thr_ok(thresh_r))
    else $error("threshold out of range");

  type_legal_a: assert property (@(posedge sys_clk) disable iff (rst) type_ok(own_type_r))
    else $error("illegal own type");

  report_store_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rpt_ok && hit[0] && !wr_acc) |=> (c_val_r[0] == $past(rpt.obs)))
    else $error("report not stored");

  foreign_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rpt_valid && rpt.loop_id != own_loop_r && !wr_acc) |=> $stable(c_val_r[0]))
    else $error("foreign report stored");

  sum_track_a: assert property (@(posedge sys_clk) disable iff (rst)
    (c_used_r == {N{1'b0}}) |=> (sum == '0))
    else $error("sum of empty group not zero");

  panel_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    reach_now |=> (panel.active && panel.state == $past(rpt_state_r)))
    else $error("panel not reporting");

  latch_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    (panel.active && latching && en_r && $stable(rpt_state_r)) |=> panel.active)
    else $error("latching state dropped");

  no_report_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!reach_now && !latching) |=> !panel.active)
    else $error("panel active below threshold");

  sum_wide_a: assert property (@(posedge sys_clk) disable iff (rst)
    sum <= SUM_W'(N * 255))
    else $error("sum overflow");

  type_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rpt_valid && rpt.det != own_type_r && !wr_acc) |=> $stable(c_val_r[0]))
    else $error("wrong type report stored");

  disable_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    !en_r |=> !panel.active)
    else $error("panel active while disabled");

  status_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    (ev != '0) |=> ((status_r & $past(ev)) == $past(ev)))
    else $error("status event lost");

  ready_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held");

endmodule : osa_summer

// >>> testbench/osa_sensor_model.sv
`timescale 1ns/10ps
module osa_sensor_model
  import osa_pkg::*;
#(
  parameter int         NLVL      = 8,
  parameter logic [7:0] ADDR_BASE = 8'h0a
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Sensor selection and target reading
  input  wire logic [2:0]  idx,
  input  wire logic [7:0]  target,
  input  wire osa_det_t    det,
  input  wire logic [3:0]  loop_id,
  // Loop broadcast
  output logic             rpt_valid,
  output osa_report_t      rpt,
  output logic             busy
);
  // ----
  // Reporting levels 0.5 to 4.0 %/ft in 0.1 units
  // ----
  localparam logic [7:0] LVL [NLVL] = '{8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h1e, 8'h23, 8'h28};
  logic [7:0] cur [8];
  logic [7:0] nxt;

  // Level crossed rising or falling
  function automatic logic hit(input logic [7:0] o, input logic [7:0] n);
    hit = 1'b0;
    for (int k = 0; k < NLVL; k++)
      if ((n > o && n == LVL[k]) || (n < o && o == LVL[k]))
        hit = 1'b1;
  endfunction : hit

  // Reading walks one count a cycle toward the target
  always_comb
  begin
    nxt = cur[idx];
    if (target > cur[idx])
      nxt = cur[idx] + 8'h01;
    else if (target < cur[idx])
      nxt = cur[idx] - 8'h01;
  end
  assign busy = cur[idx] != target;

  // Idle broadcast lines toggle so stale data never looks valid
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rpt_valid <= 1'b0;
      rpt       <= '0;
      for (int k = 0; k < 8; k++)
        cur[k] <= 8'h00;
    end
    else
    begin
      rpt_valid <= hit(cur[idx], nxt);
      if (hit(cur[idx], nxt))
        rpt <= '{loop_id: loop_id, addr: ADDR_BASE + {5'h0, idx}, det: det, obs: nxt};
      else
        rpt <= osa_report_t'(~rpt);
      cur[idx] <= nxt;
    end
  end
endmodule : osa_sensor_model

// >>> testbench/osa_summer_tb.sv
`timescale 1ns/10ps
module osa_summer_tb
  import osa_pkg::*;
;
  typedef struct packed {
    logic [2:0]  idx;
    logic [7:0]  tgt;
    logic [7:0]  val;
    logic [10:0] sum;
    logic        act;
  } osa_row_t;
  localparam osa_row_t ROWS [6] = '{
    '{3'h0, 8'h0c, 8'h0a, 11'h00a, 1'b0}, '{3'h1, 8'h14, 8'h14, 11'h01e, 1'b0},
    '{3'h2, 8'h09, 8'h05, 11'h023, 1'b0}, '{3'h3, 8'h05, 8'h05, 11'h028, 1'b1},
    '{3'h1, 8'h0d, 8'h0e, 11'h022, 1'b0}, '{3'h7, 8'h28, 8'h28, 11'h04a, 1'b1}};
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, rpt_valid, irq, busy, err;
  logic [7:0]  paddr, m_target;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  m_idx;
  osa_det_t    m_det;
  osa_report_t rpt;
  osa_panel_t  panel;
  int          errors, n_compared;

  osa_summer dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rpt_valid(rpt_valid), .rpt(rpt), .panel(panel), .irq(irq));
  osa_sensor_model model (.sys_clk(sys_clk), .rst(rst), .idx(m_idx), .target(m_target), .det(m_det),
    .loop_id(4'h1), .rpt_valid(rpt_valid), .rpt(rpt), .busy(busy));

  // ----
  // Tasks
  // ----
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task automatic run(input logic [2:0] i, input logic [7:0] t);
    int n;
    @(posedge sys_clk);
    m_idx <= i;
    m_target <= t;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 300);
    if (busy !== 1'b0)
    begin
      errors++;
      summarize();
    end
    repeat (5) @(posedge sys_clk);
  endtask : run

  // ----
  // Stimulus
  // ----
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata, m_idx, m_target} <= {1'b1, 54'h0};
    m_det = DET_PHOTO;
    errors = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    chk({28'h0, panel}, {28'h0, 1'b0, RPT_SUM_ALARM});
    rchk(REG_THRESH, 32'h28);
    rchk(REG_CTRL, 32'h100);
    rchk(REG_SUM, 32'h0);
    $display("test reset done");
    apb(1'b1, REG_CTRL, 32'h1001);
    for (int i = 0; i < 8; i++)
      apb(1'b1, REG_CONTRIB0 + 8'(4 * i), 32'h1000a + i);
    foreach (ROWS[r])
    begin
      run(ROWS[r].idx, ROWS[r].tgt);
      rchk(REG_VALUE0 + {3'h0, ROWS[r].idx, 2'h0}, {24'h0, ROWS[r].val});
      rchk(REG_SUM, {21'h0, ROWS[r].sum});
      chk({31'h0, panel.active}, {31'h0, ROWS[r].act});
    end
    $display("test rows done");
    for (int s = 0; s < 6; s++)
    begin
      apb(1'b1, REG_CTRL, 32'h1001 | (s << 8));
      repeat (3) @(posedge sys_clk);
      chk({28'h0, panel}, {28'h0, 1'b1, 3'(s)});
    end
    apb(1'b1, REG_CTRL, 32'h1601);
    rchk(REG_CTRL, 32'h1501);
    apb(1'b1, REG_CTRL, 32'h1041);
    rchk(REG_CTRL, 32'h1501);
    apb(1'b1, REG_CTRL, 32'h1001);
    $display("test states done");
    apb(1'b1, REG_THRESH, 32'h07);
    apb(1'b1, REG_THRESH, 32'h69);
    rchk(REG_THRESH, 32'h28);
    apb(1'b1, REG_THRESH, 32'h64);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, panel.active}, 32'h0);
    apb(1'b1, REG_THRESH, 32'h2b);
    rchk(REG_THRESH, 32'h64);
    apb(1'b1, REG_CTRL, 32'h1201);
    apb(1'b1, REG_THRESH, 32'h28);
    apb(1'b1, REG_THRESH, 32'h64);
    repeat (3) @(posedge sys_clk);
    chk({28'h0, panel}, {28'h0, 1'b1, RPT_SUPV_LATCH});
    apb(1'b1, REG_CTRL, 32'h1001);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, panel.active}, 32'h0);
    apb(1'b1, REG_THRESH, 32'h28);
    $display("test threshold done");
    repeat (3) @(posedge sys_clk);
    rchk(REG_STATUS, 32'h7);
    apb(1'b1, REG_IRQ_MASK, 32'h8);
    @(posedge sys_clk);
    m_det <= DET_ION;
    run(3'h0, 8'h14);
    rchk(REG_VALUE0, 32'h0a);
    chk({31'h0, irq}, 32'h1);
    rchk(REG_STATUS, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    m_det <= DET_PHOTO;
    $display("test reject done");
    apb(1'b1, REG_CONTRIB0 + 8'h1c, 32'h10011);
    rchk(REG_VALUE0 + 8'h1c, 32'h0);
    rchk(REG_SUM, 32'h22);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 8'h80, 32'h1);
    chk({31'h0, err}, 32'h1);
    $display("test slots done");
    @(posedge sys_clk);
    rst <= 1'b1;
    m_target <= 8'h00;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk({28'h0, panel}, {28'h0, 1'b0, RPT_SUM_ALARM});
    rchk(REG_CTRL, 32'h100);
    rchk(REG_CONTRIB0, 32'h0);
    $display("test second reset done");
    summarize();
  end
endmodule : osa_summer_tb
